// *** rtl/run_source_pkg.sv ***
/*
 Shared constants for the run-command source selector: register map,
 field codes, reset values, the motor state encoding and the state record.
 Assumes a 32-bit APB slave with byte addresses and one word per register.
*/
package run_source_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_SOURCE = 8'h00;
    localparam logic [7:0] OFF_KEY_DIR = 8'h04;
    localparam logic [7:0] OFF_PREVENT = 8'h08;
    localparam logic [7:0] OFF_PWR_RUN = 8'h0C;
    localparam logic [7:0] OFF_RST_RESTART = 8'h10;
    localparam logic [7:0] OFF_TERM_FUNC1 = 8'h14;
    localparam logic [7:0] OFF_TERM_FUNC5 = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;

    // Command source codes
    localparam logic [1:0] SRC_KEYPAD = 2'h0;
    localparam logic [1:0] SRC_TERM_FWD_REV = 2'h1;
    localparam logic [1:0] SRC_TERM_RUN_DIR = 2'h2;
    localparam logic [1:0] SRC_SERIAL = 2'h3;

    // Terminal function codes
    localparam logic [4:0] FUNC_RUN = 5'h00;
    localparam logic [4:0] FUNC_DIR = 5'h01;
    localparam logic [4:0] FUNC_MAX = 5'h1B;

    // Run prevention codes
    localparam logic [1:0] PREV_NONE = 2'h0;
    localparam logic [1:0] PREV_FWD = 2'h1;
    localparam logic [1:0] PREV_REV = 2'h2;

    // Terminal counts per build
    localparam int NUM_TERM = 5;
    localparam logic [4:0] TERM_MASK_STD = 5'h07;
    localparam logic [4:0] TERM_MASK_ADV = 5'h1F;

    // Reset values
    localparam logic [1:0] RST_SOURCE = 2'h1;
    localparam logic RST_KEY_DIR = 1'h0;
    localparam logic [1:0] RST_PREVENT = 2'h0;
    localparam logic RST_PWR_RUN = 1'h0;
    localparam logic RST_RST_RESTART = 1'h0;
    localparam logic [4:0][4:0] RST_TERM_FUNC =
        {5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

    // Status word bit positions
    localparam int STAT_RUN = 0;
    localparam int STAT_REV = 1;
    localparam int STAT_TRIP = 2;
    localparam int STAT_HOLD = 3;
    localparam int STAT_SRC_LO = 4;

    // Motor command state, one-hot
    typedef enum logic [2:0] {
        MOT_IDLE = 3'b001,
        MOT_FWD = 3'b010,
        MOT_REV = 3'b100
    } motor_state_t;

    // Whole state of the selector
    typedef struct packed {
        logic [1:0] source;
        logic key_dir;
        logic [1:0] prevent;
        logic pwr_run_en;
        logic rst_restart_en;
        logic [4:0][4:0] term_func;
        logic key_run;
        logic tripped;
        logic hold_off;
        logic hold_cause_pwr;
        motor_state_t motor;
        logic run_cmd;
        logic reverse_cmd;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sel_state_t;

endpackage

// *** rtl/run_source_select.sv ***
/*
 Run-command source selector with an APB register file. Chooses where
 run and direction come from (keypad, terminals in two styles, serial
 link), applies run prevention, power-on run and restart after a trip
 reset, and drives registered run and reverse commands to the drive.
 Assumes all inputs are synchronous to pclk, keypad keys and the fault
 reset are one-cycle pulses, and the serial protocol block supplies a
 decoded run and direction level.

// How it works
// - Source code 2 takes run from one terminal and direction from another.
// - In that mode a terminal with function 0 is run; alone it runs forward.
// - In that mode a terminal with function 1 active turns the run to reverse.
// - Each terminal has a function field of 0 to 27; first 0, second 1.
// - Three terminals in the standard build and five in the advanced one.
// - Source code 3 takes run only from the serial link, advanced build only.
// - Run prevention 0 allows all, 1 blocks forward and 2 blocks reverse.
// - The keypad direction applies only while the source code is 0.
// - The keypad direction stays readable and writable in every mode.
// - With power-on run set, an active terminal run starts after power-up.
// - With restart set, an active terminal run resumes after a trip reset.
// - Source code 0 starts and stops from the keypad run and stop keys.
// - Source code 1 runs forward or reverse by terminal; both or none stop.
*/
`timescale 1ns/1ps
module run_source_select
    import run_source_pkg::*;
#(
    parameter bit advanced_io = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command inputs
    input wire logic [4:0] terminal_in,
    input wire logic key_run_press,
    input wire logic key_stop_press,
    input wire logic serial_run,
    input wire logic serial_reverse,
    // Protection
    input wire logic fault_trip,
    input wire logic fault_reset,
    // Drive commands
    output logic run_cmd,
    output logic reverse_cmd
);

    sel_state_t st_reg;
    sel_state_t st_next;
    logic term_run;
    logic term_dir;
    logic [4:0] present_mask;

    // Fitted terminals depend on the build
    assign present_mask = advanced_io ? TERM_MASK_ADV : TERM_MASK_STD;

    // Terminal function resolution
    terminal_decode u_decode (
        .terminal_in(terminal_in),
        .term_func(st_reg.term_func),
        .present_mask(present_mask),
        .run_active(term_run),
        .dir_active(term_dir)
    );

    // Index of a terminal function register, or NUM_TERM when none
    // Only exact word addresses decode; a byte inside a word is refused
    function automatic int term_index(input logic [7:0] addr);
        int idx;
        idx = NUM_TERM;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (addr == OFF_TERM_FUNC1 + 8'(4 * i)) begin
                idx = i;
            end
        end
        return idx;
    endfunction

    // Whether a terminal is fitted in this build
    function automatic logic term_fitted(input int idx);
        return (idx < NUM_TERM) && present_mask[idx[2:0]];
    endfunction

    // Whether a register exists and whether a write value is legal
    function automatic logic [1:0] check_access(input logic [7:0] addr,
                                                input logic wr,
                                                input logic [31:0] d);
        logic known;
        logic legal;
        int idx;
        known = 1'b1;
        legal = 1'b1;
        idx = term_index(addr);
        // Unknown addresses refuse both ways; known ones refuse bad writes
        unique case (addr)
            OFF_SOURCE: begin
                // The serial source exists only in the advanced build
                legal = (d[31:2] == '0) &&
                    (advanced_io || d[1:0] != SRC_SERIAL);
            end
            OFF_KEY_DIR: begin
                legal = (d[31:1] == '0);
            end
            OFF_PREVENT: begin
                legal = (d[31:2] == '0) && (d[1:0] != 2'h3);
            end
            OFF_PWR_RUN, OFF_RST_RESTART: begin
                legal = (d[31:1] == '0);
            end
            OFF_STATUS: begin
                legal = ~wr;
            end
            default: begin
                if (term_fitted(idx)) begin
                    legal = (d[31:5] == '0) && (d[4:0] <= FUNC_MAX);
                end else begin
                    known = 1'b0;
                end
            end
        endcase
        return {known, legal | ~wr};
    endfunction

    // Read value of a register
    function automatic logic [31:0] read_word(input sel_state_t s,
                                              input logic [7:0] addr);
        logic [31:0] w;
        int idx;
        w = 32'h0000_0000;
        idx = term_index(addr);
        unique case (addr)
            OFF_SOURCE: begin
                w[1:0] = s.source;
            end
            OFF_KEY_DIR: begin
                w[0] = s.key_dir;
            end
            OFF_PREVENT: begin
                w[1:0] = s.prevent;
            end
            OFF_PWR_RUN: begin
                w[0] = s.pwr_run_en;
            end
            OFF_RST_RESTART: begin
                w[0] = s.rst_restart_en;
            end
            OFF_STATUS: begin
                w[STAT_RUN] = s.run_cmd;
                w[STAT_REV] = s.reverse_cmd;
                w[STAT_TRIP] = s.tripped;
                w[STAT_HOLD] = s.hold_off;
                w[STAT_SRC_LO +: 2] = s.source;
            end
            default: begin
                if (term_fitted(idx)) begin
                    w[4:0] = s.term_func[idx[2:0]];
                end
            end
        endcase
        return w;
    endfunction

    // Next state: bus, fault tracking, source resolution, motor command
    always_comb begin
        logic acc_first;
        logic commit;
        logic [1:0] chk;
        logic terminal_src;
        logic src_run;
        logic term_pending;
        logic req_run;
        logic req_rev;
        logic blocked;
        logic trip_cleared;
        int idx;
        st_next = st_reg;
        acc_first = psel && penable && !st_reg.pready;
        commit = psel && penable && st_reg.pready && pwrite &&
            !st_reg.pslverr;
        chk = check_access(paddr, pwrite, pwdata);
        idx = term_index(paddr);
        terminal_src = (st_reg.source == SRC_TERM_FWD_REV) ||
            (st_reg.source == SRC_TERM_RUN_DIR);
        src_run = 1'b0;
        req_run = 1'b0;
        req_rev = 1'b0;

        // One wait state: answer is prepared in the first access cycle
        st_next.pready = acc_first;
        st_next.pslverr = acc_first && !(chk[1] && chk[0]);
        st_next.prdata = (acc_first && !pwrite && chk[1]) ?
            read_word(st_reg, paddr) : 32'h0000_0000;

        // Writes land only on the edge that completes the transfer
        if (commit) begin
            unique case (paddr)
                OFF_SOURCE: begin
                    st_next.source = pwdata[1:0];
                end
                OFF_KEY_DIR: begin
                    st_next.key_dir = pwdata[0];
                end
                OFF_PREVENT: begin
                    st_next.prevent = pwdata[1:0];
                end
                OFF_PWR_RUN: begin
                    st_next.pwr_run_en = pwdata[0];
                end
                OFF_RST_RESTART: begin
                    st_next.rst_restart_en = pwdata[0];
                end
                default: begin
                    if (term_fitted(idx)) begin
                        st_next.term_func[idx[2:0]] = pwdata[4:0];
                    end
                end
            endcase
        end

        // Trip flag: a new trip in the reset cycle keeps it set
        // When the two race, staying tripped is the safer reading
        trip_cleared = st_reg.tripped && fault_reset && !fault_trip;
        if (fault_trip) begin
            st_next.tripped = 1'b1;
        end else if (fault_reset) begin
            st_next.tripped = 1'b0;
        end

        // Terminal run level as the present mode sees it
        term_pending = (st_reg.source == SRC_TERM_FWD_REV) ?
            (term_run || term_dir) : term_run;

        // Hold-off keeps a standing terminal run from starting the motor
        // until it is released, unless the matching auto-start is set
        // The serial source is left out: the upper controller decides
        // for itself when to run after power-up or a trip reset
        if (!term_pending) begin
            st_next.hold_off = 1'b0;
        end else if (st_reg.hold_cause_pwr && st_reg.pwr_run_en) begin
            st_next.hold_off = 1'b0;
        end else if (!st_reg.hold_cause_pwr && st_reg.rst_restart_en) begin
            st_next.hold_off = 1'b0;
        end
        if (trip_cleared) begin
            st_next.hold_off = 1'b1;
            st_next.hold_cause_pwr = 1'b0;
        end

        // Keypad run latch; stop wins so a held stop is always obeyed
        // Keys are single pulses, so the run request must be kept here
        if (key_run_press && st_reg.source == SRC_KEYPAD) begin
            st_next.key_run = 1'b1;
        end
        if (key_stop_press || fault_trip || st_reg.tripped ||
            st_reg.source != SRC_KEYPAD) begin
            st_next.key_run = 1'b0;
        end

        // Resolve the request for the selected source
        // In forward/reverse style both terminals on is a stop, not reverse
        unique case (st_reg.source)
            SRC_KEYPAD: begin
                src_run = st_reg.key_run;
                req_rev = st_reg.key_dir;
            end
            SRC_TERM_FWD_REV: begin
                src_run = term_run ^ term_dir;
                req_rev = term_dir && !term_run;
            end
            SRC_TERM_RUN_DIR: begin
                src_run = term_run;
                req_rev = term_dir;
            end
            SRC_SERIAL: begin
                src_run = serial_run;
                req_rev = serial_reverse;
            end
        endcase
        req_run = src_run && !st_reg.tripped && !fault_trip &&
            !(terminal_src && st_reg.hold_off);

        // A blocked direction counts as stop
        // Prevention acts on the resolved direction, so a blocked request
        // halts the motor instead of turning it the other way
        blocked = (!req_rev && st_reg.prevent == PREV_FWD) ||
            (req_rev && st_reg.prevent == PREV_REV);

        if (!req_run || blocked) begin
            st_next.motor = MOT_IDLE;
        end else if (req_rev) begin
            st_next.motor = MOT_REV;
        end else begin
            st_next.motor = MOT_FWD;
        end
        st_next.run_cmd = (st_next.motor != MOT_IDLE);
        st_next.reverse_cmd = (st_next.motor == MOT_REV);
    end

    // State register; hold-off starts set so power-up obeys its setting
    // Settings return to defaults on every reset, so power-on run only
    // acts once software has written it while the power-up hold stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.source <= RST_SOURCE;
            st_reg.key_dir <= RST_KEY_DIR;
            st_reg.prevent <= RST_PREVENT;
            st_reg.pwr_run_en <= RST_PWR_RUN;
            st_reg.rst_restart_en <= RST_RST_RESTART;
            st_reg.term_func <= RST_TERM_FUNC;
            st_reg.key_run <= 1'b0;
            st_reg.tripped <= 1'b0;
            st_reg.hold_off <= 1'b1;
            st_reg.hold_cause_pwr <= 1'b1;
            st_reg.motor <= MOT_IDLE;
            st_reg.run_cmd <= 1'b0;
            st_reg.reverse_cmd <= 1'b0;
            st_reg.pready <= 1'b0;
            st_reg.pslverr <= 1'b0;
            st_reg.prdata <= 32'h0000_0000;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    // No logic after the flops: outputs move only on pclk edges and on presetn going low
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign run_cmd = st_reg.run_cmd;
    assign reverse_cmd = st_reg.reverse_cmd;

endmodule // run_source_select

// *** rtl/terminal_decode.sv ***
/*
 Combines the multi-function input terminals into the run and the
 direction request according to each terminal's function code.
 Assumes terminal levels are already synchronous to the clock.
*/
`timescale 1ns/1ps
module terminal_decode
    import run_source_pkg::*;
(
    // Terminal levels and their settings
    input wire logic [4:0] terminal_in,
    input wire logic [4:0][4:0] term_func,
    input wire logic [4:0] present_mask,
    // Combined requests
    output logic run_active,
    output logic dir_active
);

    // A terminal counts when fitted, active and given the code asked for
    function automatic logic any_with(input logic [4:0] lv,
                                      input logic [4:0][4:0] fn,
                                      input logic [4:0] mask,
                                      input logic [4:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (mask[i] && lv[i] && (fn[i] == code)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Run terminal and direction terminal requests
    always_comb begin
        run_active = any_with(terminal_in, term_func, present_mask,
                              FUNC_RUN);
        dir_active = any_with(terminal_in, term_func, present_mask,
                              FUNC_DIR);
    end

endmodule // terminal_decode

// *** verification/command_far_side.sv ***
/*
 Far side of the selector: terminal switches, keypad keys and the
 serial controller's decoded levels. Tasks are called after a pclk edge.
*/
`timescale 1ns/1ps
module command_far_side (
    // Clock
    input wire logic pclk,
    // Commands toward the selector
    output logic [4:0] terminal_in,
    output logic key_run_press,
    output logic key_stop_press,
    output logic serial_run,
    output logic serial_reverse
);
    // Terminal 1 closed at power-up so the power-up hold has a cause
    initial begin
        terminal_in = 5'h01;
        key_run_press = 1'b0;
        key_stop_press = 1'b0;
        serial_run = 1'b0;
        serial_reverse = 1'b0;
    end

    // Switch levels
    task automatic set_terminals(input logic [4:0] v);
        terminal_in <= v;
    endtask

    // A key press lasts one cycle
    task automatic press(input logic stop);
        key_run_press <= !stop;
        key_stop_press <= stop;
        @(posedge pclk);
        key_run_press <= 1'b0;
        key_stop_press <= 1'b0;
    endtask

    // Station, protocol and speed already match, so levels are live
    task automatic set_serial(input logic run, input logic rev);
        serial_run <= run;
        serial_reverse <= rev;
    endtask
endmodule // command_far_side

// *** verification/run_source_checker_sva.sv ***
/*
 Checker for run_source_select: APB answer timing and trip lockout.
 Assumes it is bound to the selector and sees only its ports.
*/
`timescale 1ns/1ps
module run_source_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Protection and drive
    input wire logic fault_trip,
    input wire logic fault_reset,
    input wire logic run_cmd
);
    logic trip_reg;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Trip flag rebuilt from its causes; a set beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_reg <= 1'b0;
        end else if (fault_trip) begin
            trip_reg <= 1'b1;
        end else if (fault_reset) begin
            trip_reg <= 1'b0;
        end
    end

    // Access phase waiting, then its answer
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence

    a_answer_one_wait: assert property (s_wait |=> s_answer)
        else $error("access not answered after one wait");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_setup_no_ready: assert property ($rose(penable) |-> !pready)
        else $error("pready in first access cycle");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_data_quiet: assert property (!(pready && !pwrite) |-> prdata == 0)
        else $error("prdata not zero outside read answer");
    a_unmapped_error: assert property (
        psel && penable && !pready && paddr > 8'h28 |=> pslverr)
        else $error("unmapped access not refused");
    a_mapped_read_ok: assert property (psel && penable && !pready &&
        !pwrite && paddr <= 8'h28 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped read refused");
    a_trip_stops: assert property (fault_trip |=> !run_cmd)
        else $error("run after trip");
    a_tripped_idle: assert property (trip_reg |-> !run_cmd)
        else $error("run while tripped");
endmodule // run_source_checker

bind run_source_select run_source_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_trip(fault_trip),
    .fault_reset(fault_reset), .run_cmd(run_cmd));

// *** verification/run_source_select_tb_top.sv ***
/*
 Testbench for run_source_select: APB register tasks and command
 scenarios with expected outputs. Assumes the far-side model and checker.
*/
`timescale 1ns/1ps
module run_source_select_tb_top import run_source_pkg::*;;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [4:0] terminal_in;
    logic key_run_press, key_stop_press, serial_run, serial_reverse;
    logic fault_trip, fault_reset, run_cmd, reverse_cmd;
    int errors, n_checks;

    // Default build: five terminals and the serial source
    run_source_select dut_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .terminal_in(terminal_in),
        .key_run_press(key_run_press), .key_stop_press(key_stop_press),
        .serial_run(serial_run), .serial_reverse(serial_reverse),
        .fault_trip(fault_trip), .fault_reset(fault_reset),
        .run_cmd(run_cmd), .reverse_cmd(reverse_cmd));
    command_far_side far_u (.pclk(pclk), .terminal_in(terminal_in),
        .key_run_press(key_run_press), .key_stop_press(key_stop_press),
        .serial_run(serial_run), .serial_reverse(serial_reverse));

    // 20 MHz clock
    always #25 pclk = ~pclk;

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        if (n >= 16) begin
            chk("pready", 1, 0);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic err);
        apb(1'b1, a, d);
        chk("write error", {31'h0, err}, {31'h0, e});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic err);
        apb(1'b0, a, 32'h0000_0000);
        chk("read data", exp, q);
        chk("read error", {31'h0, err}, {31'h0, e});
    endtask

    // Let the one-cycle answer land, then look at the commands
    task automatic expect_cmd(input logic run, input logic rev);
        repeat (3) @(posedge pclk);
        chk("run_cmd", {31'h0, run}, {31'h0, run_cmd});
        chk("reverse_cmd", {31'h0, rev}, {31'h0, reverse_cmd});
    endtask

    task automatic pulse(input logic clear);
        fault_trip <= !clear;
        fault_reset <= clear;
        @(posedge pclk);
        fault_trip <= 1'b0;
        fault_reset <= 1'b0;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200_000;
        errors++;
        finish_test();
    end

    initial begin
        logic blk;
        // Address, direction and data are left open until the first setup
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        fault_trip = 1'b0;
        fault_reset = 1'b0;
        errors = 0;
        n_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFF_SOURCE, 32'h0000_0001, 1'b0);
        rd(OFF_KEY_DIR, 32'h0000_0000, 1'b0);
        rd(OFF_PREVENT, 32'h0000_0000, 1'b0);
        rd(OFF_PWR_RUN, 32'h0000_0000, 1'b0);
        rd(OFF_RST_RESTART, 32'h0000_0000, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rd(OFF_TERM_FUNC1 + 8'(4 * i), 32'(i), 1'b0);
        end
        rd(OFF_STATUS, 32'h0000_0018, 1'b0);
        expect_cmd(1'b0, 1'b0);
        $display("test reset values done");
        rd(8'h2C, 32'h0000_0000, 1'b1);
        wr(OFF_PREVENT, 32'h0000_0003, 1'b1);
        wr(OFF_TERM_FUNC1 + 8'h04, 32'h0000_001C, 1'b1);
        wr(OFF_TERM_FUNC1 + 8'h04, 32'h0000_001B, 1'b0);
        rd(OFF_TERM_FUNC1 + 8'h04, 32'h0000_001B, 1'b0);
        wr(OFF_TERM_FUNC1 + 8'h04, 32'h0000_0001, 1'b0);
        wr(OFF_STATUS, 32'h0000_0000, 1'b1);
        $display("test refusals done");
        wr(OFF_PWR_RUN, 32'h0000_0001, 1'b0);
        expect_cmd(1'b1, 1'b0);
        far_u.set_terminals(5'h03);
        expect_cmd(1'b0, 1'b0);
        far_u.set_terminals(5'h02);
        expect_cmd(1'b1, 1'b1);
        far_u.set_terminals(5'h00);
        expect_cmd(1'b0, 1'b0);
        $display("test power-on and forward/reverse done");
        wr(OFF_SOURCE, 32'h0000_0002, 1'b0);
        for (int p = 0; p < 3; p++) begin
            for (int d = 0; d < 2; d++) begin
                wr(OFF_PREVENT, 32'(p), 1'b0);
                far_u.set_terminals({3'h0, d[0], 1'b1});
                blk = (p == 1 && d == 0) || (p == 2 && d == 1);
                expect_cmd(!blk, d[0] && !blk);
            end
        end
        wr(OFF_PREVENT, 32'h0000_0000, 1'b0);
        wr(OFF_TERM_FUNC5, 32'h0000_0001, 1'b0);
        far_u.set_terminals(5'h11);
        expect_cmd(1'b1, 1'b1);
        wr(OFF_KEY_DIR, 32'h0000_0001, 1'b0);
        rd(OFF_KEY_DIR, 32'h0000_0001, 1'b0);
        far_u.set_terminals(5'h01);
        expect_cmd(1'b1, 1'b0);
        $display("test run and direction done");
        pulse(1'b0);
        expect_cmd(1'b0, 1'b0);
        pulse(1'b1);
        expect_cmd(1'b0, 1'b0);
        far_u.set_terminals(5'h00);
        expect_cmd(1'b0, 1'b0);
        far_u.set_terminals(5'h01);
        expect_cmd(1'b1, 1'b0);
        wr(OFF_RST_RESTART, 32'h0000_0001, 1'b0);
        pulse(1'b0);
        expect_cmd(1'b0, 1'b0);
        pulse(1'b1);
        expect_cmd(1'b1, 1'b0);
        $display("test trip and restart done");
        wr(OFF_SOURCE, 32'h0000_0000, 1'b0);
        expect_cmd(1'b0, 1'b0);
        far_u.press(1'b0);
        expect_cmd(1'b1, 1'b1);
        far_u.press(1'b1);
        expect_cmd(1'b0, 1'b0);
        $display("test keypad done");
        far_u.set_terminals(5'h00);
        wr(OFF_SOURCE, 32'h0000_0003, 1'b0);
        far_u.set_serial(1'b1, 1'b1);
        expect_cmd(1'b1, 1'b1);
        far_u.set_serial(1'b1, 1'b0);
        expect_cmd(1'b1, 1'b0);
        far_u.set_serial(1'b0, 1'b0);
        expect_cmd(1'b0, 1'b0);
        $display("test serial done");
        finish_test();
    end
endmodule // run_source_select_tb_top
